// File: src/cpms_pkg.sv
// Purpose: Shared constants and types for the control pin mode select
// Assumes: APB byte addresses, 32-bit data, 8-bit serial registers
// Notes: Serial frame is address byte then data byte, MSB first
package cpms_pkg;
  // ==========================================================
  // APB register map
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_SREG = 8'h0C;
  // STATUS bit positions
  localparam int unsigned ST_RST_PIN = 0;
  localparam int unsigned ST_READOUT = 1;
  localparam int unsigned ST_STANDBY = 2;
  localparam int unsigned ST_OE = 3;
  localparam int unsigned ST_INIT = 4;
  // Interrupt events
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned EV_SER_WR = 0;
  localparam int unsigned EV_RANGE = 1;
  localparam int unsigned EV_INIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // ==========================================================
  // Serial programming interface
  localparam int unsigned SER_AW = 8;
  localparam int unsigned SER_DW = 8;
  localparam int unsigned SER_FRAME = 16;
  localparam int unsigned SER_CW = 5;
  localparam logic [7:0] SA_CTRL = 8'h00;
  localparam logic [7:0] SA_PWR = 8'h01;
  localparam logic [7:0] SA_MISC = 8'h02;
  localparam int unsigned CTRL_READOUT = 0;
  localparam int unsigned CTRL_SWRST = 1;
  localparam int unsigned PWR_STANDBY = 0;
  localparam logic [7:0] SER_CTRL_RST = 8'h00;
  localparam logic [7:0] SER_PWR_RST = 8'h00;
  localparam logic [7:0] SER_MISC_RST = 8'h00;
  // ==========================================================
  // Types
  typedef struct packed {
    logic serial_clock_pin;
    logic serial_data_pin;
    logic serial_enable_pin;
  } cpms_ser_pins_t;
  typedef struct packed {
    logic stb;
    logic [SER_AW-1:0] addr;
    logic [SER_DW-1:0] data;
  } cpms_ser_wr_t;
  typedef enum logic [2:0] {
    CPMS_S_IDLE = 3'b001,
    CPMS_S_ADDR = 3'b010,
    CPMS_S_DATA = 3'b100
  } cpms_ser_state_t;
endpackage : cpms_pkg

// File: src/cpms_ser_shift.sv
// Purpose: Serial frame shifter with register readback shift-out
// Assumes: Pins synchronous to pclk; pclk much faster than the serial clock
// Notes: A frame aborts when the enable pin rises or mode is lost
`timescale 1ns/10ps
`default_nettype none
module cpms_ser_shift (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins and mode
  input wire cpms_pkg::cpms_ser_pins_t pins,
  input wire logic enable,
  input wire logic readout,
  // Readback source
  output logic [cpms_pkg::SER_AW-1:0] rd_addr,
  input wire logic [cpms_pkg::SER_DW-1:0] rdata,
  // Results
  output logic rb_bit,
  output cpms_pkg::cpms_ser_wr_t wr
);
  import cpms_pkg::*;
  localparam logic [SER_CW-1:0] ADDR_LAST = SER_CW'(SER_AW - 1);
  localparam logic [SER_CW-1:0] FRAME_LAST = SER_CW'(SER_FRAME - 1);
  typedef struct packed {
    cpms_ser_state_t st;
    logic clk_prev;
    logic loaded;
    logic [SER_CW-1:0] cnt;
    logic [SER_FRAME-1:0] sh;
    logic [SER_DW-1:0] rsh;
    logic rb;
    cpms_ser_wr_t wr;
  } cpms_ser_reg_t;
  cpms_ser_reg_t q;
  cpms_ser_reg_t d;
  logic rise;
  logic stop;
  assign rise = pins.serial_clock_pin & ~q.clk_prev;
  assign stop = ~enable | pins.serial_enable_pin;
  assign rd_addr = q.sh[SER_AW-1:0];
  assign rb_bit = q.rb;
  assign wr = q.wr;
  always_comb begin
    d = q;
    d.clk_prev = pins.serial_clock_pin;
    d.wr.stb = 1'b0;
    case (q.st)
      CPMS_S_IDLE: begin
        d.cnt = '0;
        d.loaded = 1'b0;
        d.rb = 1'b0;
        if (!stop) d.st = CPMS_S_ADDR;
      end
      CPMS_S_ADDR: begin
        if (stop) begin
          d.st = CPMS_S_IDLE;
        end else if (rise) begin
          d.sh = {q.sh[SER_FRAME-2:0], pins.serial_data_pin};
          d.cnt = q.cnt + 1'b1;
          if (q.cnt == ADDR_LAST) d.st = CPMS_S_DATA;
        end
      end
      CPMS_S_DATA: begin
        if (stop) begin
          d.st = CPMS_S_IDLE;
        end else if (!q.loaded) begin
          // MSB is presented before the first data clock edge
          d.loaded = 1'b1;
          d.rb = readout & rdata[SER_DW-1];
          d.rsh = {rdata[SER_DW-2:0], 1'b0};
        end else if (rise) begin
          d.sh = {q.sh[SER_FRAME-2:0], pins.serial_data_pin};
          d.cnt = q.cnt + 1'b1;
          d.rb = readout & q.rsh[SER_DW-1];
          d.rsh = {q.rsh[SER_DW-2:0], 1'b0};
          if (q.cnt == FRAME_LAST) begin
            d.st = CPMS_S_IDLE;
            d.wr.stb = 1'b1;
            d.wr.addr = d.sh[SER_FRAME-1:SER_DW];
            d.wr.data = d.sh[SER_DW-1:0];
          end
        end
      end
      default: d.st = CPMS_S_IDLE;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= '{st: CPMS_S_IDLE, default: '0};
    else q <= d;
  end
endmodule : cpms_ser_shift
`default_nettype wire

// File: src/cpms_out_buf.sv
// Purpose: Registered output buffers for converter data and clock
// Assumes: Enable pin is synchronous to pclk
// Notes: Output enables are active low; high means high impedance
`timescale 1ns/10ps
`default_nettype none
module cpms_out_buf #(
  parameter int unsigned DW = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Sources
  input wire logic oe_pin,
  input wire logic [DW-1:0] data_in,
  input wire logic dclk_in,
  // Buffered pins
  output logic [DW-1:0] data_out,
  output logic data_oe_n,
  output logic clk_out,
  output logic clk_oe_n
);
  if (DW < 1 || DW > 32) begin : g_bad_dw
    $error("cpms_out_buf: DW must be 1 to 32");
  end
  typedef struct packed {
    logic [DW-1:0] data;
    logic doe_n;
    logic clk;
    logic coe_n;
  } cpms_ob_reg_t;
  cpms_ob_reg_t q;
  cpms_ob_reg_t d;
  always_comb begin
    d.data = data_in;
    d.clk = dclk_in;
    d.doe_n = ~oe_pin;
    d.coe_n = ~oe_pin;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) q <= '{doe_n: 1'b1, coe_n: 1'b1, default: '0};
    else q <= d;
  end
  assign data_out = q.data;
  assign data_oe_n = q.doe_n;
  assign clk_out = q.clk;
  assign clk_oe_n = q.coe_n;
endmodule : cpms_out_buf
`default_nettype wire

// File: src/cpms_top.sv
// Purpose: Control pin mode select for a converter's control pins
// Assumes: All pins synchronous to pclk (40 MHz), APB slave access
// Notes: Serial registers are held at defaults while reset_pin is high
//
// Overview of operation
// - Output buffers enabled while enable pin high
// - Readback bit 0 drives out-of-range flag
// - Readback bit 1 shifts register reads out
// - Reset pin high holds registers at default
// - Reset high: enable pin not serial enable
// - Serial clock used only while reset low
// - Data pin is standby control when reset high
// - Serial enable honoured only while reset low
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module cpms_top #(
  parameter int unsigned ADC_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [cpms_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cpms_pkg::APB_DW-1:0] pwdata,
  output logic [cpms_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins
  input wire logic reset_pin,
  input wire cpms_pkg::cpms_ser_pins_t ser_pins,
  input wire logic output_buffer_enable_pin,
  // Converter core
  input wire logic adc_overrange,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic adc_dclk,
  // Pin outputs
  output logic overrange_or_readout_pin,
  output logic standby,
  output logic [ADC_W-1:0] data_out,
  output logic data_oe_n,
  output logic clk_out,
  output logic clk_oe_n,
  // Interrupt
  output logic irq
);
  import cpms_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (ADC_W < 1 || ADC_W > 32) begin : g_bad_w
    $error("cpms_top: ADC_W must be 1 to 32");
  end

  // ==========================================================
  // Helpers
  function automatic logic apb_hit(
    input logic [APB_AW-1:0] a,
    input logic [APB_AW-1:0] ofs
  );
    apb_hit = (a == ofs);
  endfunction : apb_hit

  function automatic logic [SER_DW-1:0] ser_read(
    input logic [SER_AW-1:0] a,
    input logic [SER_DW-1:0] ctrl,
    input logic [SER_DW-1:0] pwr,
    input logic [SER_DW-1:0] misc
  );
    case (a)
      SA_CTRL: ser_read = ctrl;
      SA_PWR: ser_read = pwr;
      SA_MISC: ser_read = misc;
      default: ser_read = '0;
    endcase
  endfunction : ser_read

  // ==========================================================
  // State
  typedef struct packed {
    logic [SER_DW-1:0] ser_ctrl;
    logic [SER_DW-1:0] ser_pwr;
    logic [SER_DW-1:0] ser_misc;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic init_done;
    logic rst_prev;
    logic range_q;
    logic range_prev;
    logic rb_pin;
    logic standby;
    logic irq;
    logic [APB_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } cpms_top_reg_t;

  cpms_top_reg_t q;
  cpms_top_reg_t d;

  // ==========================================================
  // Serial interface
  cpms_ser_wr_t ser_wr;
  logic [SER_AW-1:0] ser_rd_addr;
  logic [SER_DW-1:0] ser_rdata;
  logic rb_bit;
  logic readout;
  logic ser_enable;

  assign readout = q.ser_ctrl[CTRL_READOUT];
  // Serial pins only act as a port while reset_pin is low
  assign ser_enable = ~reset_pin;
  assign ser_rdata = ser_read(ser_rd_addr, q.ser_ctrl, q.ser_pwr,
                              q.ser_misc);

  cpms_ser_shift u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .pins(ser_pins),
    .enable(ser_enable),
    .readout(readout),
    .rd_addr(ser_rd_addr),
    .rdata(ser_rdata),
    .rb_bit(rb_bit),
    .wr(ser_wr)
  );

  // ==========================================================
  // Output buffers
  cpms_out_buf #(
    .DW(ADC_W)
  ) u_ob (
    .pclk(pclk),
    .presetn(presetn),
    .oe_pin(output_buffer_enable_pin),
    .data_in(adc_data),
    .dclk_in(adc_dclk),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .clk_out(clk_out),
    .clk_oe_n(clk_oe_n)
  );

  // ==========================================================
  // Next state
  logic acc_wr;
  logic swrst;
  logic ser_ok;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;

  always_comb begin
    d = q;
    acc_wr = psel & penable & q.pready & pwrite;
    ser_ok = ser_wr.stb & ~reset_pin;
    swrst = ser_ok & (ser_wr.addr == SA_CTRL) &
            ser_wr.data[CTRL_SWRST];
    ev = '0;
    w1c = '0;

    // Serial register bank
    if (reset_pin) begin
      // Tied high: registers stay at their defaults
      d.ser_ctrl = SER_CTRL_RST;
      d.ser_pwr = SER_PWR_RST;
      d.ser_misc = SER_MISC_RST;
    end else if (swrst) begin
      // Software reset initialises the bank in place of a pin pulse
      d.ser_ctrl = SER_CTRL_RST;
      d.ser_pwr = SER_PWR_RST;
      d.ser_misc = SER_MISC_RST;
    end else if (ser_ok) begin
      case (ser_wr.addr)
        SA_CTRL: begin
          d.ser_ctrl = ser_wr.data;
          d.ser_ctrl[CTRL_SWRST] = 1'b0;
        end
        SA_PWR: begin
          // Readback mode protects PWR and MISC from stray writes; CTRL stays writable
          if (!readout) d.ser_pwr = ser_wr.data;
        end
        SA_MISC: begin
          if (!readout) d.ser_misc = ser_wr.data;
        end
        default: begin
          d.ser_misc = q.ser_misc;
        end
      endcase
    end

    // Pin history
    d.rst_prev = reset_pin;
    d.range_q = adc_overrange;
    d.range_prev = q.range_q;

    // Initialisation seen: pin pulse falling, tie-high or software reset
    if ((q.rst_prev & ~reset_pin) | reset_pin | swrst) begin
      d.init_done = 1'b1;
    end

    // Events
    ev[EV_SER_WR] = ser_ok;
    ev[EV_RANGE] = q.range_q & ~q.range_prev;
    ev[EV_INIT] = (q.rst_prev & ~reset_pin) | swrst;

    // Interrupt status and mask; a new event wins over its clear
    if (acc_wr && apb_hit(paddr, OFS_IRQ_STAT)) begin
      w1c = pwdata[IRQ_W-1:0];
    end
    if (acc_wr && apb_hit(paddr, OFS_IRQ_MASK)) begin
      d.irq_mask = pwdata[IRQ_W-1:0];
    end
    d.irq_stat = (q.irq_stat & ~w1c) | ev;
    d.irq = |(d.irq_stat & d.irq_mask);

    // Shared pin: flag or readback shift-out
    if (readout) begin
      d.rb_pin = rb_bit;
    end else begin
      d.rb_pin = q.range_q;
    end

    // Standby: data pin while tied high, else register bit
    if (reset_pin) begin
      d.standby = ser_pins.serial_data_pin;
    end else begin
      d.standby = q.ser_pwr[PWR_STANDBY];
    end

    // APB: answer in the cycle after setup, one wait-free access
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.prdata = '0;
    if (psel && !penable) begin
      d.pready = 1'b1;
      if (apb_hit(paddr, OFS_STATUS)) begin
        d.prdata[ST_RST_PIN] = reset_pin;
        d.prdata[ST_READOUT] = readout;
        d.prdata[ST_STANDBY] = q.standby;
        d.prdata[ST_OE] = output_buffer_enable_pin;
        d.prdata[ST_INIT] = q.init_done;
      end else if (apb_hit(paddr, OFS_IRQ_STAT)) begin
        d.prdata[IRQ_W-1:0] = q.irq_stat;
      end else if (apb_hit(paddr, OFS_IRQ_MASK)) begin
        d.prdata[IRQ_W-1:0] = q.irq_mask;
      end else if (apb_hit(paddr, OFS_SREG)) begin
        d.prdata[3*SER_DW-1:0] = {q.ser_misc, q.ser_pwr, q.ser_ctrl};
      end else begin
        d.pslverr = 1'b1;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{ser_ctrl: SER_CTRL_RST,
             ser_pwr: SER_PWR_RST,
             ser_misc: SER_MISC_RST,
             irq_mask: IRQ_MASK_RST,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign overrange_or_readout_pin = q.rb_pin;
  assign standby = q.standby;
  assign irq = q.irq;
endmodule : cpms_top
`default_nettype wire

// File: tb/cpms_top_asserts.sv
// Purpose: Port checks for the control pin mode select
// Assumes: One pclk domain, presetn asynchronous active low
// Notes: A saturating count of reset-pin-high cycles gates lookbacks
`timescale 1ns/10ps
`default_nettype none
module cpms_top_asserts #(
  parameter int unsigned ADC_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB answer
  input wire logic psel,
  input wire logic penable,
  input wire logic [cpms_pkg::APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic reset_pin,
  input wire cpms_pkg::cpms_ser_pins_t ser_pins,
  input wire logic output_buffer_enable_pin,
  input wire logic adc_overrange,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic overrange_or_readout_pin,
  input wire logic standby,
  input wire logic [ADC_W-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic clk_oe_n
);
  import cpms_pkg::*;
  logic [2:0] hi_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Helper: a fresh count after any reset keeps $past off reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 3'h0;
    end else begin
      hi_q <= !reset_pin ? 3'h0 : hi_q + {2'h0, hi_q != 3'h7};
    end
  end
  // ==========================================================
  // Properties
  property p_data_oe;
    $past(presetn) |-> data_oe_n == !$past(output_buffer_enable_pin);
  endproperty
  a_data_oe: assert property (p_data_oe)
    else $error("data enable does not follow the enable pin");
  property p_clk_oe;
    $past(presetn) |-> clk_oe_n == data_oe_n;
  endproperty
  a_clk_oe: assert property (p_clk_oe)
    else $error("clock enable differs from data enable");
  property p_data;
    $past(presetn) && !data_oe_n |-> data_out == $past(adc_data);
  endproperty
  a_data: assert property (p_data)
    else $error("driven data is not the core data");
  property p_ovr;
    hi_q > 3'h4 |-> overrange_or_readout_pin == $past(adc_overrange, 2);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("shared pin is not the range flag");
  property p_stby;
    hi_q > 3'h2 |-> standby == $past(ser_pins.serial_data_pin);
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby does not follow the data pin");
  property p_ack;
    psel && !penable |=> pready;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no answer after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer held longer than one cycle");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err)
    else $error("error flag without answer");
  property p_idle;
    !pready |-> prdata == '0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data not zero outside answer");
  c_err: cover property (pslverr);
  c_stby: cover property (hi_q > 3'h2 && standby);
  c_float: cover property ($past(presetn) && data_oe_n);
endmodule : cpms_top_asserts
bind cpms_top cpms_top_asserts #(.ADC_W(ADC_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reset_pin(reset_pin), .ser_pins(ser_pins),
  .output_buffer_enable_pin(output_buffer_enable_pin),
  .adc_overrange(adc_overrange), .adc_data(adc_data),
  .overrange_or_readout_pin(overrange_or_readout_pin),
  .standby(standby), .data_out(data_out), .data_oe_n(data_oe_n),
  .clk_oe_n(clk_oe_n)
);
`default_nettype wire

// File: tb/cpms_host_model.sv
// Purpose: Host controller driving the serial control pins
// Assumes: Serial clock half period of HALF pclk cycles
// Notes: Idle levels match the pin pulls, so nothing floats
`timescale 1ns/10ps
`default_nettype none
module cpms_host_model #(
  parameter int unsigned HALF = 3
) (
  // Clock
  input wire logic pclk,
  // Pins
  output var cpms_pkg::cpms_ser_pins_t pins,
  input wire logic readout_pin
);
  import cpms_pkg::*;
  // ==========================================================
  // Idle is clock low, data low, enable high
  initial begin
    pins = 3'b001;
  end
  task automatic level(input logic c, input logic d, input logic e);
    @(posedge pclk);
    pins <= {c, d, e};
  endtask : level
  // Frame of nb bits; the readout pin is taken late in the low phase of each data bit (r > 7)
  task automatic send(input logic [7:0] a, input logic [7:0] d,
                      input int nb, output logic [7:0] rb);
    logic [15:0] fr;
    fr = {a, d};
    rb = 8'h00;
    @(posedge pclk);
    pins.serial_enable_pin <= 1'b0;
    for (int r = 0; r < nb; r++) begin
      pins.serial_data_pin <= fr[15-r];
      pins.serial_clock_pin <= 1'b0;
      repeat (HALF) @(posedge pclk);
      if (r > 7) begin
        rb[15-r] = readout_pin;
      end
      pins.serial_clock_pin <= 1'b1;
      repeat (HALF) @(posedge pclk);
    end
    pins <= 3'b001;
    repeat (HALF) @(posedge pclk);
  endtask : send
endmodule : cpms_host_model
`default_nettype wire

// File: tb/tb_control_pin_mode_select.sv
// Purpose: Self-checking bench for the control pin mode select
// Assumes: Host model owns the serial pins, bench owns the rest
// Notes: Random phase runs with the reset pin high
`timescale 1ns/10ps
`default_nettype none
module tb_control_pin_mode_select;
  import cpms_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic reset_pin, oe, orng, dclk, irq, pin, stby, d_oe_n, c_oe_n, c_out;
  logic [7:0] paddr, rb;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] adc_data, d_out;
  cpms_ser_pins_t pins;
  integer seed;
  int err_total, checks, cyc;
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  cpms_host_model u_host (.pclk(pclk), .pins(pins), .readout_pin(pin));
  cpms_top #(.ADC_W(12)) u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin(reset_pin), .ser_pins(pins),
    .output_buffer_enable_pin(oe), .adc_overrange(orng),
    .adc_data(adc_data), .adc_dclk(dclk),
    .overrange_or_readout_pin(pin), .standby(stby), .data_out(d_out),
    .data_oe_n(d_oe_n), .clk_out(c_out), .clk_oe_n(c_oe_n), .irq(irq)
  );
  // ==========================================================
  // Expectations, compares and bus cycles
  function automatic logic [31:0] st_exp(input logic ro, input logic sb);
    st_exp = 32'h0;
    st_exp[ST_RST_PIN] = reset_pin;
    st_exp[ST_READOUT] = ro;
    st_exp[ST_STANDBY] = sb;
    st_exp[ST_OE] = oe;
    st_exp[ST_INIT] = 1'b1;
  endfunction : st_exp
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask : chk_pin
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // This wait ends when pready is seen high, or at the bench timeout
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk_pin(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic end_of_test();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h79732D61;
    {presetn, psel, penable, pwrite, orng, dclk} = 6'h00;
    {reset_pin, oe} = 2'b11;
    paddr = 8'h00;
    pwdata = 32'h0;
    adc_data = 12'h000;
    err_total = 0;
    checks = 0;
    cyc = 0;
    tick(2);
    presetn <= 1'b1;
    tick(3);
    reset_pin <= 1'b0;
    tick(3);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk_reg(rd, 32'h4);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_reg(rd, st_exp(1'b0, 1'b0));
    orng <= 1'b1;
    tick(4);
    chk_pin(pin, 1'b1);
    chk_pin(irq, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    tick(3);
    chk_pin(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'h6);
    orng <= 1'b0;
    tick(3);
    chk_pin(irq, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk_reg({er, rd[30:0]}, 32'h8000_0000);
    u_host.send(SA_PWR, 8'h01, 16, rb);
    tick(4);
    chk_pin(stby, 1'b1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk_reg(rd, 32'h1);
    u_host.send(SA_MISC, 8'hA5, 10, rb);
    tick(4);
    apb(1'b0, OFS_SREG, 32'h0);
    chk_reg(rd, 32'h0000_0100);
    u_host.send(SA_CTRL, 8'h01, 16, rb);
    tick(4);
    u_host.send(SA_PWR, 8'h00, 16, rb);
    chk_reg({24'h0, rb}, 32'h1);
    chk_pin(stby, 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk_reg(rd, st_exp(1'b1, 1'b1));
    reset_pin <= 1'b1;
    tick(4);
    apb(1'b0, OFS_SREG, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b1, OFS_IRQ_STAT, 32'h7);
    for (int i = 0; i < 60; i++) begin
      u_host.level(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
      oe <= 1'($random(seed));
      adc_data <= 12'($random(seed));
      dclk <= ~dclk;
      tick(2);
      chk_pin(d_oe_n, ~oe);
      chk_pin(c_oe_n, ~oe);
      chk_pin(c_out, dclk);
      chk_reg({20'h0, d_out}, {20'h0, adc_data});
      chk_pin(stby, pins.serial_data_pin);
    end
    u_host.level(1'b0, 1'b0, 1'b1);
    tick(4);
    apb(1'b0, OFS_SREG, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk_reg(rd & 32'h1, 32'h0);
    end_of_test();
  end
endmodule : tb_control_pin_mode_select
`default_nettype wire
